// File: hdl/trig_seq_pkg.sv
// package for the two-channel trigger arm sequencer
package trig_seq_pkg;
   localparam int NUM_CH = 2;
   // register byte offsets
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_CFG_A = 8'h04;
   localparam logic [7:0] OFS_CFG_B = 8'h08;
   localparam logic [7:0] OFS_GLOBAL = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_ERROR = 8'h14;
   // command register bit positions
   localparam int CMD_STOP_A = 0;
   localparam int CMD_STOP_B = 1;
   localparam int CMD_ARM_A = 2;
   localparam int CMD_ARM_B = 3;
   localparam int CMD_ARM_ALL = 4;
   localparam int CMD_FULL_RESET = 5;
   localparam int CMD_PRESET = 6;
   localparam int CMD_LOCAL = 7;
   localparam int CMD_FORCE_A = 8;
   localparam int CMD_FORCE_B = 9;
   // channel config field positions
   localparam int CFG_ARM_ALWAYS = 0;
   localparam int CFG_AUTO_DELAY = 1;
   localparam int CFG_SRC_LSB = 4;
   // global register fields
   localparam int GLB_ARM_ALL_ALWAYS = 0;
   localparam int GLB_SWEEP = 1;
   localparam int GLB_DUAL = 2;
   // error codes (low 16 bits, two's complement)
   localparam logic [15:0] ERR_INIT_IGNORED = 16'hff2b;
   localparam logic [15:0] ERR_SUFFIX_RANGE = 16'hff72;
   // settling interval
   localparam int SETTLE_NS = 1000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // reset values and bus response codes
   localparam logic RST_AUTO_DELAY = 1'b1;
   localparam logic RST_ARM_ALWAYS = 1'b1;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [2:0] {
      SRC_IMMEDIATE, SRC_BUS, SRC_HOLD, SRC_BACK_PANEL, SRC_OWN_LEVEL_A, SRC_OWN_LEVEL_B
   } trig_src_t;

   typedef enum {ST_IDLE, ST_WAIT, ST_SETTLE, ST_MEASURE} ch_state_t;

   typedef struct packed {
      logic arm_always;
      logic auto_delay;
      trig_src_t src;
   } ch_cfg_t;
endpackage

// File: hdl/trigger_arm_sequencer.sv
// two-channel trigger arm sequencer with axi4-lite control
// Functional notes
// R01: stop command moves addressed channel from waiting to idle.
// R02: stop leaves all other trigger settings untouched.
// R03: with arm-always on, stop returns channel straight to waiting.
// R04: arm commands overlap; bus keeps accepting while armed or measuring.
// R05: pending flag high while armed work outstanding, low in idle.
// R06: trigger cycle is leaving waiting and starting a measurement.
// R07: arm-always off: idle until armed, back to idle after one cycle.
// R08: arm-always on: next cycle starts directly, never via idle.
// R09: local, preset, power-up: arm-always set unless level or back-panel source.
// R10: full reset clears per-channel arm-always and arm-all-always.
// R11: arm-always reads 1 for continuous, 0 for single.
// R12: arm-once waits for trigger, then measures and stores result.
// R13: immediate source measures as soon as arm-once executes.
// R14: arm when not idle or arm-always on is ignored, error -213.
// R15: arm-all-always sets every sequence continuous; reads back 1 or 0.
// R16: arm-all-once arms every channel in one operation.
// R17: per-channel arm-always off at full reset, on at preset/power-up.
// R18: auto delay inserts settling interval before measuring.
// R19: auto delay off measures immediately on trigger.
// R20: auto delay ignored with immediate source.
// R21: no trigger delay in power or frequency sweep mode.
// R22: reset turns auto delay on.
// R23: channel 1 is A, 2 is B; single-channel model rejects B.
// R24: each channel has own idle/waiting/measuring state, reset idle.
`timescale 1ns/1ps
module trigger_arm_sequencer
   import trig_seq_pkg::*;
#(
   parameter int SETTLE_CNT = SETTLE_CYCLES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // trigger events and measurement handshake
   input wire logic [NUM_CH-1:0] trig_event,
   input wire logic [NUM_CH-1:0] meas_done,
   output logic [NUM_CH-1:0] meas_start,
   output logic [NUM_CH-1:0] store_result,
   output logic [NUM_CH-1:0] pending
);

   ch_state_t state [NUM_CH];
   ch_cfg_t cfg [NUM_CH];
   logic arm_all_always;
   logic sweep_mode;
   logic dual_model;
   logic [15:0] last_error;
   logic [15:0] settle_cnt [NUM_CH];

   // write channel capture
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic [31:0] cmd;

   function automatic logic [31:0] cfg_word(input ch_cfg_t c);
      cfg_word = 32'h0;
      cfg_word[CFG_ARM_ALWAYS] = c.arm_always; // R11
      cfg_word[CFG_AUTO_DELAY] = c.auto_delay;
      cfg_word[CFG_SRC_LSB +: 3] = c.src;
   endfunction

   function automatic logic keeps_arm(input trig_src_t s);
      keeps_arm = (s == SRC_OWN_LEVEL_A) || (s == SRC_OWN_LEVEL_B) || (s == SRC_BACK_PANEL);
   endfunction

   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign cmd = (wr_fire && aw_addr == OFS_CMD && w_strb[0]) ? w_data : 32'h0;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr <= OFS_GLOBAL) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // read channel
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         case (s_axi_araddr)
            OFS_CMD: s_axi_rdata <= 32'h0;
            OFS_CFG_A: s_axi_rdata <= cfg_word(cfg[0]);
            OFS_CFG_B: s_axi_rdata <= cfg_word(cfg[1]);
            OFS_GLOBAL: s_axi_rdata <= {29'h0, dual_model, sweep_mode, arm_all_always}; // R15
            OFS_STATUS: s_axi_rdata <= {24'h0, 2'(state[1]), 2'(state[0]), 2'h0, pending};
            OFS_ERROR: s_axi_rdata <= {16'h0, last_error};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // global settings
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         arm_all_always <= 1'b0;
         sweep_mode <= 1'b0;
         dual_model <= 1'b1;
      end else if (cmd[CMD_FULL_RESET]) begin
         arm_all_always <= 1'b0; // R10
      end else if (wr_fire && aw_addr == OFS_GLOBAL && w_strb[0]) begin
         arm_all_always <= w_data[GLB_ARM_ALL_ALWAYS]; // R15
         sweep_mode <= w_data[GLB_SWEEP];
         dual_model <= w_data[GLB_DUAL];
      end
   end

   // error register: arm refused or channel B on single model
   always_ff @(posedge clk_sys) begin
      logic refused;
      refused = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
         if ((cmd[CMD_ARM_A + i] || cmd[CMD_ARM_ALL])
             && (state[i] != ST_IDLE || cfg[i].arm_always))
            refused = 1'b1;
      end
      if (rst) begin
         last_error <= 16'h0;
      end else if (!dual_model && wr_fire
                   && (aw_addr == OFS_CFG_B || (cmd & 32'h0000020a) != 32'h0)) begin
         last_error <= ERR_SUFFIX_RANGE; // R23
      end else if (refused) begin
         last_error <= ERR_INIT_IGNORED; // R14
      end else if (wr_fire && aw_addr == OFS_ERROR) begin
         last_error <= 16'h0;
      end
   end

   generate
      for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
         logic ch_ok;
         logic cont;
         logic arm_cmd;
         logic direct;
         assign ch_ok = (i == 0) || dual_model; // R23
         assign cont = cfg[i].arm_always || arm_all_always; // R15
         assign arm_cmd = ch_ok && (cmd[CMD_ARM_A + i] || cmd[CMD_ARM_ALL]); // R16
         // immediate source or sweep bypasses settling
         assign direct = !cfg[i].auto_delay || cfg[i].src == SRC_IMMEDIATE || sweep_mode;

         // configuration
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               cfg[i].arm_always <= RST_ARM_ALWAYS; // R17
               cfg[i].auto_delay <= RST_AUTO_DELAY;
               cfg[i].src <= SRC_IMMEDIATE;
            end else if (cmd[CMD_FULL_RESET]) begin
               cfg[i].arm_always <= 1'b0; // R10
               cfg[i].auto_delay <= 1'b1; // R22
               cfg[i].src <= SRC_IMMEDIATE;
            end else if (cmd[CMD_PRESET] || cmd[CMD_LOCAL]) begin
               if (!keeps_arm(cfg[i].src))
                  cfg[i].arm_always <= 1'b1; // R09
            end else if (wr_fire && ch_ok && aw_addr == (i == 0 ? OFS_CFG_A : OFS_CFG_B)
                         && w_strb[0]) begin
               cfg[i].arm_always <= w_data[CFG_ARM_ALWAYS];
               cfg[i].auto_delay <= w_data[CFG_AUTO_DELAY];
               cfg[i].src <= trig_src_t'(w_data[CFG_SRC_LSB +: 3]);
            end
         end

         // sequencer state
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               state[i] <= ST_IDLE; // R24
               settle_cnt[i] <= 16'h0;
               meas_start[i] <= 1'b0;
               store_result[i] <= 1'b0;
            end else begin
               meas_start[i] <= 1'b0;
               store_result[i] <= 1'b0;
               if (ch_ok && cmd[CMD_STOP_A + i]) begin
                  // R02: only the state is touched
                  state[i] <= cont ? ST_WAIT : ST_IDLE; // R01 R03
               end else begin
                  case (state[i])
                     ST_IDLE: begin
                        if (cont || (arm_cmd && !cfg[i].arm_always))
                           state[i] <= ST_WAIT; // R07 R12
                     end
                     ST_WAIT: begin
                        if (cfg[i].src == SRC_IMMEDIATE || trig_event[i]
                            || (ch_ok && cmd[CMD_FORCE_A + i])) begin
                           if (direct) begin
                              state[i] <= ST_MEASURE; // R06 R13 R19 R20 R21
                              meas_start[i] <= 1'b1;
                           end else begin
                              state[i] <= ST_SETTLE; // R18
                              settle_cnt[i] <= 16'(SETTLE_CNT);
                           end
                        end
                     end
                     ST_SETTLE: begin
                        if (settle_cnt[i] <= 16'h1) begin
                           state[i] <= ST_MEASURE; // R18
                           meas_start[i] <= 1'b1;
                        end else begin
                           settle_cnt[i] <= settle_cnt[i] - 16'h1;
                        end
                     end
                     ST_MEASURE: begin
                        if (meas_done[i]) begin
                           store_result[i] <= 1'b1; // R12
                           state[i] <= cont ? ST_WAIT : ST_IDLE; // R07 R08
                        end
                     end
                     default: state[i] <= ST_IDLE;
                  endcase
               end
            end
         end

         always_ff @(posedge clk_sys) begin
            if (rst)
               pending[i] <= 1'b0;
            else
               pending[i] <= (state[i] != ST_IDLE) || arm_cmd || cont; // R05 R04
         end
      end
   endgenerate

endmodule // trigger_arm_sequencer

// File: verif/trig_seq_checker.sv
// port checker for the trigger arm sequencer
`timescale 1ns/1ps
module trig_seq_checker
   import trig_seq_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // measurement side
   input wire logic [NUM_CH-1:0] meas_start,
   input wire logic [NUM_CH-1:0] store_result,
   input wire logic [NUM_CH-1:0] pending
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_wr_answer; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
   property p_b_readies; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   property p_b_close; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   property p_rd_answer; s_rd_taken |=> s_axi_rvalid; endproperty
   property p_start_pulse; meas_start[0] |=> !meas_start[0]; endproperty
   property p_start_pend; meas_start[0] |=> pending[0]; endproperty
   property p_store_pulse; store_result[0] |=> !store_result[0]; endproperty
   property p_rst_quiet;
      $past(rst) |-> !s_axi_bvalid && !s_axi_rvalid && pending == '0 && meas_start == '0;
   endproperty
   a_wr_answer: assert property (p_wr_answer)
      else $error("write not answered");
   a_b_readies: assert property (p_b_readies)
      else $error("write readies high during response");
   a_b_close: assert property (p_b_close)
      else $error("write response held after handshake");
   a_rd_answer: assert property (p_rd_answer)
      else $error("read not answered");
   a_start_pulse: assert property (p_start_pulse)
      else $error("start pulse too long");
   a_start_pend: assert property (p_start_pend)
      else $error("pending low while measuring");
   a_store_pulse: assert property (p_store_pulse)
      else $error("store pulse too long");
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("outputs active after reset");
endmodule // trig_seq_checker

bind trigger_arm_sequencer trig_seq_checker chk_u (.*);

// File: verif/meas_engine_model.sv
// measurement engine model answering start pulses
`timescale 1ns/1ps
module meas_engine_model
   import trig_seq_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // answer speed and handshake
   input wire logic slow,
   input wire logic [NUM_CH-1:0] meas_start,
   output logic [NUM_CH-1:0] meas_done
);
   int cnt [NUM_CH];
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < NUM_CH; i++) begin
         meas_done[i] <= 1'b0;
         if (rst) cnt[i] <= 0;
         else if (meas_start[i]) cnt[i] <= slow ? 12 : 2;
         else if (cnt[i] == 1) begin
            cnt[i] <= 0;
            meas_done[i] <= 1'b1;
         end else if (cnt[i] > 1) cnt[i] <= cnt[i] - 1;
      end
   end
endmodule // meas_engine_model

// File: verif/trigger_arm_sequencer_tb_top.sv
// self-checking bench for the trigger arm sequencer
`timescale 1ns/1ps
module trigger_arm_sequencer_tb_top;
   import trig_seq_pkg::*;
   localparam int SC = 3;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, slow = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, meas_done, meas_start, store_result, pending;
   logic [1:0] trig_event = 2'h0;
   int n_mismatch = 0, n_compared = 0, n_start = 0, n_store = 0, n0, s0, lo, hi;
   trigger_arm_sequencer #(.SETTLE_CNT(SC)) dut_u (.*);
   meas_engine_model eng_u (.*);
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (meas_start[0]) n_start++;
      if (store_result[0]) n_store++;
   end
   task automatic test_done();
      if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_up();
      n_mismatch++;
      $display("Error at %0t: wait bound ran out", $time);
      test_done();
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (n > 50) give_up();
      end while (!s_axi_bvalid);
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (n > 50) give_up();
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
   endtask
   task automatic chkrd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      rd_reg(a, d);
      chk(d & m, e);
   endtask
   // arm channel a, pulse its trigger, count cycles to measurement start
   task automatic trig_lat(output int n);
      wr(OFS_CMD, 32'h04);
      tick(2);
      trig_event <= 2'h1;
      tick(1);
      trig_event <= 2'h0;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
         if (n > 200) give_up();
      end while (!meas_start[0]);
      tick(30);
   endtask
   initial begin
      tick(8);
      rst <= 1'b0;
      chkrd(OFS_CFG_A, 32'h73, 32'h03);
      chkrd(OFS_CFG_B, 32'h73, 32'h03);
      chkrd(OFS_GLOBAL, 32'h07, 32'h04);
      tick(60);
      chk(32'(n_start > 3), 32'h1);
      chk(32'(pending[0]), 32'h1);
      wr(OFS_CMD, 32'h20);
      chkrd(OFS_CFG_A, 32'h03, 32'h02);
      tick(30);
      chkrd(OFS_STATUS, 32'hf3, 32'h00);
      n0 = n_start;
      s0 = n_store;
      wr(OFS_CMD, 32'h04);
      tick(30);
      chk(n_start - n0, 32'h1);
      chk(n_store - s0, 32'h1);
      chkrd(OFS_STATUS, 32'h31, 32'h00);
      wr(OFS_CFG_A, 32'h22);
      wr(OFS_CMD, 32'h04);
      chkrd(OFS_STATUS, 32'h31, 32'h11);
      wr(OFS_CMD, 32'h04);
      chkrd(OFS_ERROR, 32'hffff, {16'h0, ERR_INIT_IGNORED});
      wr(OFS_ERROR, 32'h0);
      chkrd(OFS_ERROR, 32'hffff, 32'h0);
      wr(OFS_CMD, 32'h01);
      chkrd(OFS_STATUS, 32'h31, 32'h00);
      wr(OFS_CMD, 32'h04);
      chkrd(OFS_STATUS, 32'h30, 32'h10);
      wr(OFS_CFG_A, 32'h23);
      wr(OFS_CMD, 32'h01);
      chkrd(OFS_STATUS, 32'h30, 32'h10);
      wr(OFS_CFG_A, 32'h30);
      wr(OFS_CMD, 32'h01);
      slow <= 1'b1;
      trig_lat(lo);
      wr(OFS_CFG_A, 32'h32);
      trig_lat(hi);
      chk(32'(hi >= lo + SC), 32'h1);
      wr(OFS_CFG_A, 32'h22);
      wr(OFS_CFG_B, 32'h22);
      wr(OFS_CMD, 32'h10);
      chkrd(OFS_STATUS, 32'hf0, 32'h50);
      wr(OFS_CFG_A, 32'h30);
      wr(OFS_CMD, 32'h40);
      chkrd(OFS_CFG_A, 32'h71, 32'h30);
      chkrd(OFS_CFG_B, 32'h71, 32'h21);
      rd_reg(8'h20, rd);
      chk({30'h0, s_axi_rresp}, {30'h0, RESP_SLVERR});
      chk(rd, 32'h0);
      wr(OFS_GLOBAL, 32'h05);
      chkrd(OFS_GLOBAL, 32'h01, 32'h01);
      wr(OFS_CMD, 32'h20);
      chkrd(OFS_GLOBAL, 32'h01, 32'h00);
      // single-channel model refuses channel b
      wr(OFS_GLOBAL, 32'h00);
      wr(OFS_CMD, 32'h08);
      chkrd(OFS_ERROR, 32'hffff, {16'h0, ERR_SUFFIX_RANGE});
      test_done();
   end
endmodule // trigger_arm_sequencer_tb_top
